// file: ddri_core.sv
`default_nettype none
`include "ddri_defs.svh"

module ddri_core #(
  parameter logic [`DDRI_INIT_W-1:0] INIT_CYCLES = `DDRI_INIT_CYC
) (
  // Clock and core reset
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  // Memory pins from the controller
  input wire logic MEM_RESET_N_IN,
  input wire logic CKE_IN,
  input wire logic CS_N_IN,
  input wire logic RAS_N_IN,
  input wire logic CAS_N_IN,
  input wire logic WE_N_IN,
  input wire logic [2:0] BA_IN,
  input wire logic [14:0] ADDR_IN,
  input wire logic ODT_IN,
  // Device status
  output logic READY_OUT,
  output logic TERM_EN_OUT,
  output logic MR_ALL_LOADED_OUT,
  output logic [3:0] MR_LOADED_OUT,
  output logic [14:0] MR0_OUT,
  output logic [14:0] MR1_OUT,
  output logic [14:0] MR2_OUT,
  output logic [14:0] MR3_OUT,
  output logic DLL_RESET_OUT,
  output logic ZQ_CAL_OUT,
  output logic CMD_ERR_OUT,
  // Burst sequencer
  output logic BURST_VALID_OUT,
  output logic BURST_WRITE_OUT,
  output logic BURST_LAST_OUT,
  output logic [2:0] BURST_BANK_OUT,
  output logic [14:0] BURST_ROW_OUT,
  output logic [9:0] BEAT_COL_EVEN_OUT,
  output logic [9:0] BEAT_COL_ODD_OUT
);

  // Pin reset is destructive and asynchronous, so it joins the core reset
  wire logic rst_any = RESET_IN | ~MEM_RESET_N_IN;

  ddri_pkg::state_t state_r;
  ddri_pkg::state_t state_nxt;
  logic [`DDRI_INIT_W-1:0] init_cnt_r;
  logic [14:0] mr_r [4];
  logic [3:0] mr_loaded_r;
  logic [`DDRI_BANKS-1:0] bank_open_r;
  logic [14:0] bank_row_r [`DDRI_BANKS];
  logic burst_act_r;
  logic burst_wr_r;
  logic burst_bc4_r;
  logic burst_il_r;
  logic burst_ap_r;
  logic [1:0] beat_pair_r;
  logic [2:0] burst_bank_r;
  logic [9:0] burst_col_r;

  // Command decode, only honoured once CKE is registered high
  wire logic cmd_ok = (state_r == ddri_pkg::ST_ACTIVE) & CKE_IN & ~CS_N_IN;
  wire logic [2:0] cmd = {RAS_N_IN, CAS_N_IN, WE_N_IN};
  wire logic is_mrs = cmd_ok & (cmd == `DDRI_CMD_MRS);
  wire logic is_act = cmd_ok & (cmd == `DDRI_CMD_ACT);
  wire logic is_pre = cmd_ok & (cmd == `DDRI_CMD_PRE);
  wire logic is_zq = cmd_ok & (cmd == `DDRI_CMD_ZQ);
  wire logic is_rw = cmd_ok & ((cmd == `DDRI_CMD_RD) | (cmd == `DDRI_CMD_WR));
  wire logic rw_bad = is_rw & ~bank_open_r[BA_IN];
  wire logic rw_go = is_rw & bank_open_r[BA_IN];
  wire logic [1:0] mr_sel = BA_IN[1:0];
  wire logic pre_all = ADDR_IN[`DDRI_AP_BIT];

  // Burst length choice from MR0 and the chop pin
  wire logic [1:0] bl_mode = mr_r[0][`DDRI_MR0_BL_LO +: 2];
  wire logic new_bc4 = (bl_mode == `DDRI_BL_FIX4) |
      ((bl_mode == `DDRI_BL_OTF) & ~ADDR_IN[`DDRI_BC_BIT]);

  // Nominal termination is on when any Rtt_Nom bit of MR1 is set
  wire logic rtt_nom_on = mr_r[1][`DDRI_MR1_RTT0_BIT] |
      mr_r[1][`DDRI_MR1_RTT1_BIT] | mr_r[1][`DDRI_MR1_RTT2_BIT];
  wire logic dll_on = ~mr_r[1][`DDRI_MR1_DLLDIS_BIT];

  wire logic last_pair = burst_act_r &
      (beat_pair_r == (burst_bc4_r ? 2'h1 : 2'h3));

  // Writes ignore the low column bits: BL8 starts at 0, BC4 at 0 or 4
  wire logic [2:0] start_col = ~burst_wr_r ? burst_col_r[2:0] :
      (burst_bc4_r ? {burst_col_r[2], 2'h0} : 3'h0);
  wire logic [2:0] beat_e = {beat_pair_r, 1'b0};
  wire logic [2:0] beat_o = {beat_pair_r, 1'b1};

  function automatic logic [2:0] order(input logic [2:0] c,
      input logic [2:0] i, input logic il);
    logic [1:0] lo;
    lo = c[1:0] + i[1:0];
    order = il ? (c ^ i) : {c[2] ^ i[2], lo};
  endfunction

  wire logic [2:0] col_e = order(start_col, beat_e, burst_il_r);
  wire logic [2:0] col_o = order(start_col, beat_o, burst_il_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ddri_pkg::ST_INTERNAL_INIT: begin
        if (init_cnt_r == INIT_CYCLES) begin
          state_nxt = ddri_pkg::ST_WAIT_CKE;
        end
      end
      ddri_pkg::ST_WAIT_CKE: begin
        if (CKE_IN) begin
          state_nxt = ddri_pkg::ST_ACTIVE;
        end
      end
      ddri_pkg::ST_ACTIVE: state_nxt = ddri_pkg::ST_ACTIVE;
      default: state_nxt = ddri_pkg::ST_INTERNAL_INIT;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or posedge rst_any) begin
    if (rst_any) begin
      state_r <= ddri_pkg::ST_INTERNAL_INIT;
      init_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ddri_pkg::ST_INTERNAL_INIT) begin
        init_cnt_r <= init_cnt_r + `DDRI_INIT_W'(1);
      end
    end
  end

  // Mode registers: every load replaces the whole register
  always_ff @(posedge CORE_CLK_IN or posedge rst_any) begin
    if (rst_any) begin
      for (int k = 0; k < 4; k++) begin
        mr_r[k] <= `DDRI_MR_RST;
      end
      mr_loaded_r <= 4'h0;
    end else if (is_mrs) begin
      mr_r[mr_sel] <= ADDR_IN;
      // DLL reset bit is self clearing, it only fires a pulse
      if (mr_sel == 2'h0) begin
        mr_r[0][`DDRI_MR0_DLLRST_BIT] <= 1'b0;
      end
      mr_loaded_r[mr_sel] <= 1'b1;
    end
  end

  // Bank table; mode loads never touch it, array data survives them
  always_ff @(posedge CORE_CLK_IN or posedge rst_any) begin
    if (rst_any) begin
      bank_open_r <= '0;
      for (int k = 0; k < `DDRI_BANKS; k++) begin
        bank_row_r[k] <= '0;
      end
    end else begin
      if (last_pair & burst_ap_r) begin
        bank_open_r[burst_bank_r] <= 1'b0;
      end
      if (is_pre) begin
        if (pre_all) begin
          bank_open_r <= '0;
        end else begin
          bank_open_r[BA_IN] <= 1'b0;
        end
      end
      if (is_act) begin
        bank_open_r[BA_IN] <= 1'b1;
        bank_row_r[BA_IN] <= ADDR_IN;
      end
    end
  end

  // Burst sequencer: two beats per clock, four clocks for a full burst
  always_ff @(posedge CORE_CLK_IN or posedge rst_any) begin
    if (rst_any) begin
      burst_act_r <= 1'b0;
      burst_wr_r <= 1'b0;
      burst_bc4_r <= 1'b0;
      burst_il_r <= 1'b0;
      burst_ap_r <= 1'b0;
      beat_pair_r <= 2'h0;
      burst_bank_r <= 3'h0;
      burst_col_r <= 10'h000;
    end else if (rw_go) begin
      burst_act_r <= 1'b1;
      burst_wr_r <= ~WE_N_IN;
      burst_bc4_r <= new_bc4;
      burst_il_r <= mr_r[0][`DDRI_MR0_BT_BIT];
      burst_ap_r <= ADDR_IN[`DDRI_AP_BIT];
      beat_pair_r <= 2'h0;
      burst_bank_r <= BA_IN;
      burst_col_r <= ADDR_IN[9:0];
    end else if (last_pair) begin
      burst_act_r <= 1'b0;
      beat_pair_r <= 2'h0;
    end else if (burst_act_r) begin
      beat_pair_r <= beat_pair_r + 2'h1;
    end
  end

  // Registered outputs
  always_ff @(posedge CORE_CLK_IN or posedge rst_any) begin
    if (rst_any) begin
      READY_OUT <= 1'b0;
      TERM_EN_OUT <= 1'b0;
      MR_ALL_LOADED_OUT <= 1'b0;
      MR_LOADED_OUT <= 4'h0;
      MR0_OUT <= `DDRI_MR_RST;
      MR1_OUT <= `DDRI_MR_RST;
      MR2_OUT <= `DDRI_MR_RST;
      MR3_OUT <= `DDRI_MR_RST;
      DLL_RESET_OUT <= 1'b0;
      ZQ_CAL_OUT <= 1'b0;
      CMD_ERR_OUT <= 1'b0;
      BURST_VALID_OUT <= 1'b0;
      BURST_WRITE_OUT <= 1'b0;
      BURST_LAST_OUT <= 1'b0;
      BURST_BANK_OUT <= 3'h0;
      BURST_ROW_OUT <= 15'h0000;
      BEAT_COL_EVEN_OUT <= 10'h000;
      BEAT_COL_ODD_OUT <= 10'h000;
    end else begin
      READY_OUT <= (state_r == ddri_pkg::ST_ACTIVE);
      // Termination held off until CKE seen high after reset
      TERM_EN_OUT <= (state_r == ddri_pkg::ST_ACTIVE) & ODT_IN &
          rtt_nom_on;
      MR_ALL_LOADED_OUT <= &mr_loaded_r;
      MR_LOADED_OUT <= mr_loaded_r;
      MR0_OUT <= mr_r[0];
      MR1_OUT <= mr_r[1];
      MR2_OUT <= mr_r[2];
      MR3_OUT <= mr_r[3];
      DLL_RESET_OUT <= is_mrs & (mr_sel == 2'h0) &
          ADDR_IN[`DDRI_MR0_DLLRST_BIT] & dll_on;
      ZQ_CAL_OUT <= is_zq;
      CMD_ERR_OUT <= rw_bad;
      BURST_VALID_OUT <= burst_act_r;
      BURST_WRITE_OUT <= burst_act_r & burst_wr_r;
      BURST_LAST_OUT <= last_pair;
      BURST_BANK_OUT <= burst_bank_r;
      BURST_ROW_OUT <= bank_row_r[burst_bank_r];
      BEAT_COL_EVEN_OUT <= {burst_col_r[9:3], col_e};
      BEAT_COL_ODD_OUT <= {burst_col_r[9:3], col_o};
    end
  end

endmodule

`default_nettype wire

// file: ddri_core_sva.sv
`default_nettype none
`include "ddri_defs.svh"
module ddri_chk #(
  parameter logic [`DDRI_INIT_W-1:0] INIT_CYCLES = `DDRI_INIT_CYC
) (
  // Clock, resets and command pins
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic MEM_RESET_N_IN,
  input wire logic CKE_IN,
  input wire logic CS_N_IN,
  input wire logic RAS_N_IN,
  input wire logic CAS_N_IN,
  input wire logic WE_N_IN,
  input wire logic [2:0] BA_IN,
  input wire logic [14:0] ADDR_IN,
  // Status and bursts
  input wire logic READY_OUT,
  input wire logic TERM_EN_OUT,
  input wire logic MR_ALL_LOADED_OUT,
  input wire logic [3:0] MR_LOADED_OUT,
  input wire logic [14:0] MR0_OUT,
  input wire logic [14:0] MR1_OUT,
  input wire logic DLL_RESET_OUT,
  input wire logic ZQ_CAL_OUT,
  input wire logic CMD_ERR_OUT,
  input wire logic BURST_LAST_OUT,
  input wire logic [9:0] BEAT_COL_EVEN_OUT
);
  wire logic ok = READY_OUT && CKE_IN && !CS_N_IN;
  wire logic [2:0] code = {RAS_N_IN, CAS_N_IN, WE_N_IN};
  wire logic mrs = ok && code == `DDRI_CMD_MRS;
  wire logic rd = ok && code == `DDRI_CMD_RD;
  wire logic rdwr = rd || ok && code == `DDRI_CMD_WR;
  wire logic chop = MR0_OUT[1:0] == `DDRI_BL_FIX4 ||
    MR0_OUT[1:0] == `DDRI_BL_OTF && !ADDR_IN[12];
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN || !MEM_RESET_N_IN);
  // Load flags pass through two register stages before the port
  property p_mrs;
    mrs |-> ##2 MR_LOADED_OUT[$past(BA_IN[1:0], 2)];
  endproperty
  a_mrs: assert property (p_mrs) else $error("load flag");
  property p_term; !READY_OUT |-> !TERM_EN_OUT; endproperty
  a_term: assert property (p_term) else $error("term early");
  property p_dll;
    mrs && BA_IN[1:0] == 2'h0 && ADDR_IN[8] && !MR1_OUT[0] |=> DLL_RESET_OUT;
  endproperty
  a_dll: assert property (p_dll) else $error("dll reset");
  property p_chop;
    rdwr && chop ##1 !rdwr && !CMD_ERR_OUT |-> ##2 BURST_LAST_OUT;
  endproperty
  a_chop: assert property (p_chop) else $error("chop length");
  property p_bl8;
    rd && MR0_OUT[1:0] == `DDRI_BL_FIX8 ##1 !rdwr && !CMD_ERR_OUT
      ##1 (!rdwr) [*2] |-> ##2 BURST_LAST_OUT;
  endproperty
  a_bl8: assert property (p_bl8) else $error("full length");
  property p_col;
    rd ##1 !CMD_ERR_OUT ##1 1'b1 |->
      BEAT_COL_EVEN_OUT == $past(ADDR_IN[9:0], 2);
  endproperty
  a_col: assert property (p_col) else $error("first column");
  property p_rdy; $rose(READY_OUT) |-> $past(CKE_IN); endproperty
  a_rdy: assert property (p_rdy) else $error("ready early");
  property p_all; MR_ALL_LOADED_OUT == &MR_LOADED_OUT; endproperty
  a_all: assert property (p_all) else $error("all loaded");
  property p_zq; ok && code == `DDRI_CMD_ZQ |=> ZQ_CAL_OUT; endproperty
  a_zq: assert property (p_zq) else $error("zq pulse");
  c_zq: cover property (ZQ_CAL_OUT);
  c_dll: cover property (DLL_RESET_OUT);
  c_err: cover property (CMD_ERR_OUT);
  c_term: cover property (TERM_EN_OUT);
endmodule
bind ddri_core ddri_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.*);
`default_nettype wire

// file: ddri_ctrl_model.sv
`default_nettype none
`include "ddri_defs.svh"
module ddri_ctrl_model #(
  parameter int INIT = 8
) (
  // Clock
  input wire logic clk,
  // Memory pins
  output logic rst_n,
  output logic cke,
  output logic cs_n,
  output logic [2:0] code,
  output logic [2:0] ba,
  output logic [14:0] addr,
  output logic odt
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {rst_n, cke, cs_n, code, ba, addr} = {2'h0, 1'b1, 3'h7, 18'h0};
    odt = 1'b0;
  end
  // Deselect drives the inverse address so stale values never look valid
  task automatic cmd(input logic [2:0] c, input logic [2:0] b,
    input logic [14:0] a);
    @(posedge clk);
    #1;
    {cs_n, code, ba, addr} = {1'b0, c, b, a};
    @(posedge clk);
    #1;
    {cs_n, code, addr} = {1'b1, `DDRI_CMD_NOP, ~a};
  endtask
  // Also serves a reset with power held
  task automatic boot();
    @(posedge clk);
    #1;
    {cke, rst_n} = 2'h0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (INIT + 5) @(posedge clk);
    #1;
    cke = 1'b1;
  endtask
  task automatic load(input logic [14:0] mr1, input logic [14:0] mr0);
    repeat (5) @(posedge clk);
    cmd(`DDRI_CMD_MRS, 3'h2, 15'h0018);
    cmd(`DDRI_CMD_MRS, 3'h3, 15'h0004);
    cmd(`DDRI_CMD_MRS, 3'h1, mr1);
    cmd(`DDRI_CMD_MRS, 3'h0, mr0);
    cmd(`DDRI_CMD_ZQ, 3'h0, 15'h0400);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic set_odt(input logic v);
    @(posedge clk);
    #1;
    odt = v;
  endtask
endmodule
`default_nettype wire

// file: ddri_defs.svh
`ifndef DDRI_DEFS_SVH
`define DDRI_DEFS_SVH

// Core clock rate
`define DDRI_CLK_MHZ 40
// Internal state initialization after reset release, in microseconds
`define DDRI_INIT_US 500
`define DDRI_INIT_CYC (`DDRI_INIT_W'(`DDRI_INIT_US * `DDRI_CLK_MHZ))
`define DDRI_INIT_W 15

// Command codes on {RAS#, CAS#, WE#} with chip select low
`define DDRI_CMD_MRS 3'h0
`define DDRI_CMD_REF 3'h1
`define DDRI_CMD_PRE 3'h2
`define DDRI_CMD_ACT 3'h3
`define DDRI_CMD_WR 3'h4
`define DDRI_CMD_RD 3'h5
`define DDRI_CMD_ZQ 3'h6
`define DDRI_CMD_NOP 3'h7

// Address bit positions
`define DDRI_AP_BIT 10
`define DDRI_BC_BIT 12
`define DDRI_MR0_BL_LO 0
`define DDRI_MR0_BT_BIT 3
`define DDRI_MR0_DLLRST_BIT 8
`define DDRI_MR1_DLLDIS_BIT 0
`define DDRI_MR1_RTT0_BIT 2
`define DDRI_MR1_RTT1_BIT 6
`define DDRI_MR1_RTT2_BIT 9

// MR0 burst length field encodings
`define DDRI_BL_FIX8 2'h0
`define DDRI_BL_OTF 2'h1
`define DDRI_BL_FIX4 2'h2

// Reset value and bank count
`define DDRI_MR_RST 15'h0000
`define DDRI_BANKS 8

`endif

// file: ddri_pkg.sv
`default_nettype none

package ddri_pkg;
  typedef enum logic [1:0] {
    ST_INTERNAL_INIT,
    ST_WAIT_CKE,
    ST_ACTIVE
  } state_t;
endpackage

`default_nettype wire

// file: tb_ddri_core.sv
`default_nettype none
`include "ddri_defs.svh"
module tb_ddri_core;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_n, cke, cs_n, odt, ready, term, all_ld, err, valid, last, wr;
  logic [2:0] code, ba, bank;
  logic [3:0] ld;
  logic [14:0] addr, mr0, mr1, mr2, mr3, row;
  logic [9:0] even, odd;
  int mismatches = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  ddri_core #(.INIT_CYCLES(15'h0008)) uut (
    .CORE_CLK_IN(clk), .RESET_IN(rst), .MEM_RESET_N_IN(rst_n),
    .CKE_IN(cke), .CS_N_IN(cs_n), .RAS_N_IN(code[2]), .CAS_N_IN(code[1]),
    .WE_N_IN(code[0]), .BA_IN(ba), .ADDR_IN(addr), .ODT_IN(odt),
    .READY_OUT(ready), .TERM_EN_OUT(term), .MR_ALL_LOADED_OUT(all_ld),
    .MR_LOADED_OUT(ld), .MR0_OUT(mr0), .MR1_OUT(mr1), .MR2_OUT(mr2),
    .MR3_OUT(mr3), .DLL_RESET_OUT(), .ZQ_CAL_OUT(), .CMD_ERR_OUT(err),
    .BURST_VALID_OUT(valid), .BURST_WRITE_OUT(wr), .BURST_LAST_OUT(last),
    .BURST_BANK_OUT(bank), .BURST_ROW_OUT(row), .BEAT_COL_EVEN_OUT(even),
    .BEAT_COL_ODD_OUT(odd));
  ddri_ctrl_model #(.INIT(8)) ctrl (.clk(clk), .rst_n(rst_n), .cke(cke),
    .cs_n(cs_n), .code(code), .ba(ba), .addr(addr), .odt(odt));
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bring_up();
    int i;
    ctrl.boot();
    check(ready, 1'b0);
    check(ld, 4'h0);
    for (i = 0; i < 20 && ready !== 1'b1; i++) begin
      @(posedge clk);
      #2;
    end
    if (ready !== 1'b1) begin
      mismatches++;
      final_report();
    end
    ctrl.load(15'h0004, 15'h0100);
    check(all_ld, 1'b1);
    check(mr1, 15'h0004);
    check(mr0, 15'h0000);
    check(mr2, 15'h0018);
    check(mr3, 15'h0004);
  endtask
  // Expected column of beat i from the burst base column
  function automatic logic [9:0] col(input logic [9:0] b,
    input logic [2:0] i, input logic il);
    col = il ? b ^ {7'h00, i} : {b[9:3], b[2] ^ i[2], b[1:0] + i[1:0]};
  endfunction
  task automatic burst(input logic [2:0] c, input logic [14:0] a,
    input logic il, input int n);
    logic [9:0] b;
    b = a[9:0];
    if (c == `DDRI_CMD_WR) begin
      b = n == 4 ? {a[9:2], 2'h0} : {a[9:3], 3'h0};
    end
    ctrl.cmd(c, 3'h3, a);
    for (int p = 0; p < n / 2; p++) begin
      @(posedge clk);
      #2;
      check(valid, 1'b1);
      check(row, 15'h1234);
      check(bank, 3'h3);
      check(wr, c == `DDRI_CMD_WR);
      check(even, col(b, 3'(2 * p), il));
      check(odd, col(b, 3'(2 * p + 1), il));
      check(last, p == n / 2 - 1);
    end
    @(posedge clk);
    #2;
    check(valid, 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    bring_up();
    $display("test init done");
    ctrl.cmd(`DDRI_CMD_ACT, 3'h3, 15'h1234);
    burst(`DDRI_CMD_RD, 15'h0005, 1'b0, 8);
    ctrl.cmd(`DDRI_CMD_PRE, 3'h3, 15'h0000);
    ctrl.cmd(`DDRI_CMD_MRS, 3'h0, 15'h0009);
    repeat (4) @(posedge clk);
    ctrl.cmd(`DDRI_CMD_ACT, 3'h3, 15'h1234);
    burst(`DDRI_CMD_RD, 15'h0005, 1'b1, 4);
    burst(`DDRI_CMD_RD, 15'h1005, 1'b1, 8);
    burst(`DDRI_CMD_WR, 15'h0005, 1'b1, 4);
    burst(`DDRI_CMD_WR, 15'h1405, 1'b1, 8);
    ctrl.cmd(`DDRI_CMD_RD, 3'h3, 15'h1005);
    #1;
    check(err, 1'b1);
    @(posedge clk);
    #2;
    check(err, 1'b0);
    $display("test bursts done");
    ctrl.set_odt(1'b1);
    @(posedge clk);
    #2;
    check(term, 1'b1);
    ctrl.set_odt(1'b0);
    @(posedge clk);
    #2;
    check(term, 1'b0);
    $display("test termination done");
    bring_up();
    $display("test warm reset done");
    final_report();
  end
endmodule
`default_nettype wire
